// [verilog/triple_timer_counter.sv]
// three timer/counters with external interrupt detection, on a byte-wide register port
// assumes one-cycle vector acks from the cpu core and asynchronous pins
`timescale 1ns/100ps
`include "timer_params.svh"

module triple_timer_counter (
    input  wire logic                core_clk,
    input  wire logic                resetn,
    input  wire logic [7:0]          sfr_addr,
    input  wire logic                sfr_write,
    input  wire logic [7:0]          sfr_wdata,
    output logic      [7:0]          sfr_rdata,
    input  wire timer_pkg::pins_type pins,
    input  wire timer_pkg::ack_type  vector_ack,
    output timer_pkg::irq_req_type   irq_req,
    output timer_pkg::baud_type      baud_clock,
    output logic                     timer2_overflow_pulse
);

    ////
    // registers

    logic [7:0] timer01_mode_control;
    logic [7:0] timer01_run_flags_control;
    logic [7:0] clock_rate_control;
    logic [7:0] timer0_count_low;
    logic [7:0] timer0_count_high;
    logic [7:0] timer1_count_low;
    logic [7:0] timer1_count_high;
    logic [7:0] timer2_control;
    logic [7:0] timer2_capture_reload_low;
    logic [7:0] timer2_capture_reload_high;
    logic [7:0] timer2_count_low;
    logic [7:0] timer2_count_high;
    logic [7:0] next_run_flags;
    logic [7:0] next_timer2_control;

    ////
    // pin synchronisers and edge detection

    timer_pkg::pins_type pin_meta;
    timer_pkg::pins_type pin_sync;
    timer_pkg::pins_type pin_prev;
    timer_pkg::pins_type pin_fall;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta <= '1;
            pin_sync <= '1;
            pin_prev <= '1;
        end else begin
            pin_meta <= pins;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign pin_fall = pin_prev & ~pin_sync;

    ////
    // shared prescaler

    logic [3:0] prescale;
    logic       tick12;
    logic       tick4;
    logic       tick2;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prescale <= 4'h0;
        end else if (prescale == `PRESCALE_TOP) begin
            prescale <= 4'h0;
        end else begin
            prescale <= prescale + 4'h1;
        end
    end

    // one free-running count keeps all three rates phase-aligned
    assign tick12 = (prescale == `PRESCALE_TOP);
    assign tick4  = (prescale[1:0] == `PRESCALE_FAST_MASK);
    assign tick2  = prescale[0];

    ////
    // timers 0 and 1

    function automatic timer_pkg::step_type step(
        input timer_pkg::timer_mode_type mode,
        input logic [7:0]                lo,
        input logic [7:0]                hi,
        input logic                      inc
    );
        timer_pkg::step_type r;
        logic [12:0]         c13;
        logic [15:0]         c16;
        r.low      = lo;
        r.high     = hi;
        r.overflow = 1'b0;
        c13        = {hi, lo[4:0]} + 13'h1;
        c16        = {hi, lo} + 16'h1;
        if (inc) begin
            unique case (mode)
                timer_pkg::MODE_13BIT: begin
                    r.low[4:0] = c13[4:0];
                    r.high     = c13[12:5];
                    r.overflow = (c13 == 13'h0000);
                end
                timer_pkg::MODE_16BIT: begin
                    r.low      = c16[7:0];
                    r.high     = c16[15:8];
                    r.overflow = (c16 == 16'h0000);
                end
                timer_pkg::MODE_RELOAD: begin
                    r.overflow = (lo == 8'hFF);
                    r.low      = r.overflow ? hi : lo + 8'h01;
                end
                timer_pkg::MODE_SPLIT: begin
                    r.overflow = (lo == 8'hFF);
                    r.low      = lo + 8'h01;
                end
            endcase
        end
        return r;
    endfunction : step

    timer_pkg::timer_mode_type timer0_mode;
    timer_pkg::timer_mode_type timer1_mode;
    logic                      timer0_split;
    logic                      timer0_gate;
    logic                      timer1_gate;
    logic                      timer0_slow;
    logic                      timer1_slow;
    logic                      timer0_inc;
    logic                      timer1_inc;
    logic                      timer0_high_inc;
    logic                      timer0_high_overflow;
    timer_pkg::step_type       timer0_step;
    timer_pkg::step_type       timer1_step;

    assign timer0_mode  = timer_pkg::timer_mode_type'(timer01_mode_control[`MODE_FIELD0_HIGH:`MODE_FIELD0_LOW]);
    assign timer1_mode  = timer_pkg::timer_mode_type'(timer01_mode_control[`MODE_FIELD1_HIGH:`MODE_FIELD1_LOW]);
    assign timer0_split = (timer0_mode == timer_pkg::MODE_SPLIT);

    assign timer0_gate = timer01_run_flags_control[`RUN_TIMER0_RUN]
                       & (~timer01_mode_control[`MODE_GATE0] | pin_sync.ext_irq_pin_zero);
    assign timer1_gate = timer01_run_flags_control[`RUN_TIMER1_RUN]
                       & (~timer01_mode_control[`MODE_GATE1] | pin_sync.ext_irq_pin_one);

    assign timer0_slow = clock_rate_control[`RATE_TIMER0] ? tick4 : tick12;
    assign timer1_slow = clock_rate_control[`RATE_TIMER1] ? tick4 : tick12;

    assign timer0_inc = timer0_gate
                      & (timer01_mode_control[`MODE_SOURCE0] ? pin_fall.timer0_event_pin : timer0_slow);
    // a timer 1 set to split mode itself stops and holds
    assign timer1_inc = timer1_gate & (timer1_mode != timer_pkg::MODE_SPLIT)
                      & (timer01_mode_control[`MODE_SOURCE1] ? pin_fall.timer1_event_pin : timer1_slow);

    // split mode high byte: divided clock only, timer 1 run bit
    assign timer0_high_inc      = timer0_split & timer01_run_flags_control[`RUN_TIMER1_RUN] & timer0_slow;
    assign timer0_high_overflow = timer0_high_inc & (timer0_count_high == 8'hFF);

    assign timer0_step = step(timer0_mode, timer0_count_low, timer0_count_high, timer0_inc);
    assign timer1_step = step(timer1_mode, timer1_count_low, timer1_count_high, timer1_inc);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timer0_count_low  <= `RESET_BYTE;
            timer0_count_high <= `RESET_BYTE;
        end else begin
            if (sfr_write && sfr_addr == `ADDR_TIMER0_LOW) begin
                timer0_count_low <= sfr_wdata;
            end else begin
                timer0_count_low <= timer0_step.low;
            end
            if (sfr_write && sfr_addr == `ADDR_TIMER0_HIGH) begin
                timer0_count_high <= sfr_wdata;
            end else if (timer0_split) begin
                timer0_count_high <= timer0_count_high + {7'h00, timer0_high_inc};
            end else begin
                timer0_count_high <= timer0_step.high;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timer1_count_low  <= `RESET_BYTE;
            timer1_count_high <= `RESET_BYTE;
        end else begin
            if (sfr_write && sfr_addr == `ADDR_TIMER1_LOW) begin
                timer1_count_low <= sfr_wdata;
            end else begin
                timer1_count_low <= timer1_step.low;
            end
            if (sfr_write && sfr_addr == `ADDR_TIMER1_HIGH) begin
                timer1_count_high <= sfr_wdata;
            end else begin
                timer1_count_high <= timer1_step.high;
            end
        end
    end

    ////
    // run and flag register; hardware sets win over acks and writes

    logic ext0_event;
    logic ext1_event;

    assign ext0_event = timer01_run_flags_control[`RUN_EXT0_TYPE]
                      ? pin_fall.ext_irq_pin_zero : ~pin_sync.ext_irq_pin_zero;
    assign ext1_event = timer01_run_flags_control[`RUN_EXT1_TYPE]
                      ? pin_fall.ext_irq_pin_one : ~pin_sync.ext_irq_pin_one;

    always_comb begin
        next_run_flags = timer01_run_flags_control;
        if (sfr_write && sfr_addr == `ADDR_RUN_FLAGS) begin
            next_run_flags = sfr_wdata;
        end
        if (vector_ack.timer0) begin
            next_run_flags[`RUN_TIMER0_OVERFLOW] = 1'b0;
        end
        if (vector_ack.timer1) begin
            next_run_flags[`RUN_TIMER1_OVERFLOW] = 1'b0;
        end
        if (vector_ack.ext0) begin
            next_run_flags[`RUN_EXT0_DETECT] = 1'b0;
        end
        if (vector_ack.ext1) begin
            next_run_flags[`RUN_EXT1_DETECT] = 1'b0;
        end
        if (timer0_step.overflow) begin
            next_run_flags[`RUN_TIMER0_OVERFLOW] = 1'b1;
        end
        // in split mode the timer 1 flag belongs to the timer 0 high byte
        if (timer0_split ? timer0_high_overflow : timer1_step.overflow) begin
            next_run_flags[`RUN_TIMER1_OVERFLOW] = 1'b1;
        end
        if (ext0_event) begin
            next_run_flags[`RUN_EXT0_DETECT] = 1'b1;
        end
        if (ext1_event) begin
            next_run_flags[`RUN_EXT1_DETECT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timer01_run_flags_control <= `RESET_BYTE;
        end else begin
            timer01_run_flags_control <= next_run_flags;
        end
    end

    ////
    // mode and rate registers

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timer01_mode_control <= `RESET_BYTE;
            clock_rate_control   <= `RESET_BYTE;
        end else if (sfr_write) begin
            if (sfr_addr == `ADDR_MODE_CONTROL) begin
                timer01_mode_control <= sfr_wdata;
            end
            if (sfr_addr == `ADDR_CLOCK_RATE) begin
                clock_rate_control <= sfr_wdata;
            end
        end
    end

    ////
    // timer 2

    logic        timer2_baud;
    logic        timer2_capture_mode;
    logic        timer2_source;
    logic        timer2_inc;
    logic        timer2_overflow;
    logic        timer2_trigger;
    logic        timer2_reload;
    logic [15:0] timer2_count;
    logic [15:0] timer2_next_count;

    assign timer2_count        = {timer2_count_high, timer2_count_low};
    assign timer2_baud         = timer2_control[`T2_RX_CLOCK_SELECT] | timer2_control[`T2_TX_CLOCK_SELECT];
    assign timer2_capture_mode = timer2_control[`T2_CAPTURE_SELECT] & ~timer2_baud;

    assign timer2_source = timer2_control[`T2_SOURCE_SELECT] ? pin_fall.timer2_event_pin
                         : timer2_baud ? tick2
                         : clock_rate_control[`RATE_TIMER2] ? tick4 : tick12;
    assign timer2_inc      = timer2_control[`T2_RUN] & timer2_source;
    assign timer2_overflow = timer2_inc & (timer2_count == 16'hFFFF);
    assign timer2_trigger  = timer2_control[`T2_TRIGGER_ENABLE] & pin_fall.timer2_trigger_pin;
    assign timer2_reload   = ~timer2_capture_mode & (timer2_overflow | (timer2_trigger & ~timer2_baud));

    always_comb begin
        if (timer2_reload) begin
            timer2_next_count = {timer2_capture_reload_high, timer2_capture_reload_low};
        end else begin
            timer2_next_count = timer2_count + {15'h0000, timer2_inc};
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timer2_count_low  <= `RESET_BYTE;
            timer2_count_high <= `RESET_BYTE;
        end else begin
            if (sfr_write && sfr_addr == `ADDR_TIMER2_LOW) begin
                timer2_count_low <= sfr_wdata;
            end else begin
                timer2_count_low <= timer2_next_count[7:0];
            end
            if (sfr_write && sfr_addr == `ADDR_TIMER2_HIGH) begin
                timer2_count_high <= sfr_wdata;
            end else begin
                timer2_count_high <= timer2_next_count[15:8];
            end
        end
    end

    // capture takes the count as it stood before this cycle's increment
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timer2_capture_reload_low  <= `RESET_BYTE;
            timer2_capture_reload_high <= `RESET_BYTE;
        end else begin
            if (sfr_write && sfr_addr == `ADDR_TIMER2_CAP_LOW) begin
                timer2_capture_reload_low <= sfr_wdata;
            end else if (timer2_capture_mode && timer2_trigger) begin
                timer2_capture_reload_low <= timer2_count_low;
            end
            if (sfr_write && sfr_addr == `ADDR_TIMER2_CAP_HIGH) begin
                timer2_capture_reload_high <= sfr_wdata;
            end else if (timer2_capture_mode && timer2_trigger) begin
                timer2_capture_reload_high <= timer2_count_high;
            end
        end
    end

    always_comb begin
        next_timer2_control = timer2_control;
        if (sfr_write && sfr_addr == `ADDR_TIMER2_CONTROL) begin
            next_timer2_control = sfr_wdata;
        end
        if (timer2_overflow && !timer2_baud) begin
            next_timer2_control[`T2_OVERFLOW_FLAG] = 1'b1;
        end
        if (timer2_trigger) begin
            next_timer2_control[`T2_EXTERNAL_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timer2_control <= `RESET_BYTE;
        end else begin
            timer2_control <= next_timer2_control;
        end
    end

    ////
    // serial clocks and overflow pulse

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            baud_clock            <= '0;
            timer2_overflow_pulse <= 1'b0;
        end else begin
            // timer 1 keeps feeding the serial port even while timer 0 is split
            baud_clock.rx_clock   <= timer2_control[`T2_RX_CLOCK_SELECT] ? timer2_overflow
                                                                         : timer1_step.overflow;
            baud_clock.tx_clock   <= timer2_control[`T2_TX_CLOCK_SELECT] ? timer2_overflow
                                                                         : timer1_step.overflow;
            timer2_overflow_pulse <= timer2_overflow & ~timer2_baud;
        end
    end

    assign irq_req.timer0 = timer01_run_flags_control[`RUN_TIMER0_OVERFLOW];
    assign irq_req.timer1 = timer01_run_flags_control[`RUN_TIMER1_OVERFLOW];
    assign irq_req.ext0   = timer01_run_flags_control[`RUN_EXT0_DETECT];
    assign irq_req.ext1   = timer01_run_flags_control[`RUN_EXT1_DETECT];
    // a software write of either flag raises the request too
    assign irq_req.timer2 = timer2_control[`T2_OVERFLOW_FLAG] | timer2_control[`T2_EXTERNAL_FLAG];

    ////
    // read port, one cycle latency

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata <= `RESET_BYTE;
        end else begin
            unique case (sfr_addr)
                `ADDR_MODE_CONTROL:    sfr_rdata <= timer01_mode_control;
                `ADDR_RUN_FLAGS:       sfr_rdata <= timer01_run_flags_control;
                `ADDR_CLOCK_RATE:      sfr_rdata <= clock_rate_control;
                `ADDR_TIMER0_LOW:      sfr_rdata <= timer0_count_low;
                `ADDR_TIMER0_HIGH:     sfr_rdata <= timer0_count_high;
                `ADDR_TIMER1_LOW:      sfr_rdata <= timer1_count_low;
                `ADDR_TIMER1_HIGH:     sfr_rdata <= timer1_count_high;
                `ADDR_TIMER2_CONTROL:  sfr_rdata <= timer2_control;
                `ADDR_TIMER2_CAP_LOW:  sfr_rdata <= timer2_capture_reload_low;
                `ADDR_TIMER2_CAP_HIGH: sfr_rdata <= timer2_capture_reload_high;
                `ADDR_TIMER2_LOW:      sfr_rdata <= timer2_count_low;
                `ADDR_TIMER2_HIGH:     sfr_rdata <= timer2_count_high;
                default:               sfr_rdata <= `RESET_BYTE;
            endcase
        end
    end

endmodule : triple_timer_counter

// [verilog/timer_params.svh]
// addresses, fields and prescale counts of the triple timer/counter
// assumes inclusion by bare name from the package and the design module
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// register addresses
`define ADDR_MODE_CONTROL    8'h00
`define ADDR_RUN_FLAGS       8'h01
`define ADDR_CLOCK_RATE      8'h02
`define ADDR_TIMER0_LOW      8'h03
`define ADDR_TIMER0_HIGH     8'h04
`define ADDR_TIMER1_LOW      8'h05
`define ADDR_TIMER1_HIGH     8'h06
`define ADDR_TIMER2_CONTROL  8'h07
`define ADDR_TIMER2_CAP_LOW  8'h08
`define ADDR_TIMER2_CAP_HIGH 8'h09
`define ADDR_TIMER2_LOW      8'h0A
`define ADDR_TIMER2_HIGH     8'h0B

// timer01_mode_control fields
`define MODE_GATE1           7
`define MODE_SOURCE1         6
`define MODE_FIELD1_HIGH     5
`define MODE_FIELD1_LOW      4
`define MODE_GATE0           3
`define MODE_SOURCE0         2
`define MODE_FIELD0_HIGH     1
`define MODE_FIELD0_LOW      0

// timer01_run_flags_control fields
`define RUN_TIMER1_OVERFLOW  7
`define RUN_TIMER1_RUN       6
`define RUN_TIMER0_OVERFLOW  5
`define RUN_TIMER0_RUN       4
`define RUN_EXT1_DETECT      3
`define RUN_EXT1_TYPE        2
`define RUN_EXT0_DETECT      1
`define RUN_EXT0_TYPE        0

// clock_rate_control fields
`define RATE_TIMER0          3
`define RATE_TIMER1          4
`define RATE_TIMER2          5

// timer2_control fields
`define T2_OVERFLOW_FLAG     7
`define T2_EXTERNAL_FLAG     6
`define T2_RX_CLOCK_SELECT   5
`define T2_TX_CLOCK_SELECT   4
`define T2_TRIGGER_ENABLE    3
`define T2_RUN               2
`define T2_SOURCE_SELECT     1
`define T2_CAPTURE_SELECT    0

// prescaler runs 0..11; ticks every 12th, 4th, 2nd clock
`define PRESCALE_TOP         4'hB
`define PRESCALE_FAST_MASK   2'h3
`define RESET_BYTE           8'h00

`endif

// [verilog/timer_pkg.sv]
// types of the triple timer/counter
// assumes timer_params.svh on the include path
`include "timer_params.svh"

package timer_pkg;

    typedef enum logic [1:0] {
        MODE_13BIT  = 2'h0,
        MODE_16BIT  = 2'h1,
        MODE_RELOAD = 2'h2,
        MODE_SPLIT  = 2'h3
    } timer_mode_type;

    typedef struct packed {
        logic timer0_event_pin;
        logic timer1_event_pin;
        logic timer2_event_pin;
        logic timer2_trigger_pin;
        logic ext_irq_pin_zero;
        logic ext_irq_pin_one;
    } pins_type;

    typedef struct packed {
        logic timer0;
        logic timer1;
        logic ext0;
        logic ext1;
    } ack_type;

    typedef struct packed {
        logic timer0;
        logic timer1;
        logic ext0;
        logic ext1;
        logic timer2;
    } irq_req_type;

    typedef struct packed {
        logic rx_clock;
        logic tx_clock;
    } baud_type;

    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic       overflow;
    } step_type;

endpackage : timer_pkg

// [bench/triple_timer_counter_asserts.sv]
// port checker of the triple timer/counter
// assumes a bind from the bench top
`timescale 1ns/100ps
`include "timer_params.svh"
module triple_timer_counter_asserts (
    input wire logic                   core_clk,
    input wire logic                   resetn,
    input wire logic [7:0]             sfr_addr,
    input wire logic                   sfr_write,
    input wire logic [7:0]             sfr_wdata,
    input wire logic [7:0]             sfr_rdata,
    input wire timer_pkg::ack_type     vector_ack,
    input wire timer_pkg::irq_req_type irq_req,
    input wire timer_pkg::baud_type    baud_clock,
    input wire logic                   timer2_overflow_pulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_pulse_one_cycle: assert property (timer2_overflow_pulse |=> !timer2_overflow_pulse)
        else $error("overflow pulse too long");
    a_pulse_sets_flag: assert property (timer2_overflow_pulse |-> irq_req.timer2)
        else $error("overflow without timer2 request");
    a_ack_clears_t0: assert property (vector_ack.timer0 |=> !irq_req.timer0)
        else $error("timer0 request survives ack");
    a_ack_clears_t1: assert property (vector_ack.timer1 |=> !irq_req.timer1)
        else $error("timer1 request survives ack");
    a_tx_clock_single: assert property (baud_clock.tx_clock |=> !baud_clock.tx_clock)
        else $error("tx clock too long");
    a_rx_clock_single: assert property (baud_clock.rx_clock |=> !baud_clock.rx_clock)
        else $error("rx clock too long");
    a_rate_bits_store: assert property (sfr_write && sfr_addr == `ADDR_CLOCK_RATE ##1
        sfr_addr == `ADDR_CLOCK_RATE |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("rate readback");
    a_reset_quiet: assert property ($rose(resetn) |-> sfr_rdata == 8'h00 && irq_req == '0)
        else $error("outputs busy after reset");
    c_pulse: cover property (timer2_overflow_pulse);
    c_baud: cover property (baud_clock.tx_clock);
    c_ext_ack: cover property (vector_ack.ext0);
endmodule : triple_timer_counter_asserts

// [bench/cpu_model.sv]
// cpu stand-in: acks each raised timer0, timer1, ext0 and ext1 request one cycle later; timer2 is never acked
// assumes ack_enable driven by the bench
`timescale 1ns/100ps
module cpu_model (
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    input  wire logic                   ack_enable,
    input  wire timer_pkg::irq_req_type irq_req,
    output timer_pkg::ack_type          vector_ack
);
    // mask own ack so a still-high request is not acked twice
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            vector_ack <= '0;
        end else begin
            vector_ack <= ack_enable ? (irq_req[4:1] & ~vector_ack) : '0;
        end
    end
endmodule : cpu_model

// [bench/triple_timer_counter_test.sv]
// self-checking bench of the triple timer/counter
// assumes design, package, checker and cpu_model compiled first
`timescale 1ns/100ps
`include "timer_params.svh"
module triple_timer_counter_test;
    logic                   core_clk = 1'b0;
    logic                   resetn = 1'b0;
    logic [7:0]             sfr_addr = 8'h00;
    logic                   sfr_write = 1'b0;
    logic [7:0]             sfr_wdata = 8'h00;
    logic [7:0]             sfr_rdata;
    timer_pkg::pins_type    pins = 6'h3F;
    timer_pkg::ack_type     vector_ack;
    timer_pkg::irq_req_type irq_req;
    timer_pkg::baud_type    baud_clock;
    logic                   timer2_overflow_pulse;
    logic                   ack_enable = 1'b0;
    int                     err_count = 0;
    int                     checked = 0;
    int                     pulses = 0;
    int                     bauds = 0;
    always #2 core_clk = ~core_clk;
    always @(negedge core_clk) begin
        pulses += timer2_overflow_pulse;
        bauds += baud_clock.tx_clock & baud_clock.rx_clock;
    end
    triple_timer_counter triple_timer_counter_inst (.core_clk(core_clk), .resetn(resetn), .sfr_addr(sfr_addr),
        .sfr_write(sfr_write), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pins(pins),
        .vector_ack(vector_ack), .irq_req(irq_req), .baud_clock(baud_clock),
        .timer2_overflow_pulse(timer2_overflow_pulse));
    cpu_model cpu_model_inst (.core_clk(core_clk), .resetn(resetn), .ack_enable(ack_enable),
        .irq_req(irq_req), .vector_ack(vector_ack));
    ////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_write = 1'b1;
        @(negedge core_clk);
        sfr_write = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        sfr_addr = a;
        @(negedge core_clk);
        d = sfr_rdata;
    endtask : rd
    task automatic ld2(input logic [31:0] v);
        for (int i = 0; i < 4; i++) begin
            wr(8'(`ADDR_TIMER2_CAP_LOW + i), v[8 * i +: 8]);
        end
    endtask : ld2
    // pins must hold each level two cycles or more
    task automatic fall(input int b, input int k);
        repeat (2 * k) begin
            @(negedge core_clk) pins[b] = ~pins[b];
            repeat (2) @(negedge core_clk);
        end
    endtask : fall
    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        #40000;
        err_count++;
        end_sim();
    end
    initial begin
        logic [7:0] lo, hi, d;
        int         c, k, g, p, ov;
        void'($urandom(94877));
        repeat (2) @(negedge core_clk);
        resetn = 1'b1;
        rd(`ADDR_CLOCK_RATE, d);
        chk("rate reset", 8'h00, d);
        lo = $urandom;
        wr(`ADDR_CLOCK_RATE, lo);
        rd(`ADDR_CLOCK_RATE, d);
        chk("rate", lo, d);
        for (int m = 0; m < 4; m++) begin
            lo = $urandom;
            hi = $urandom;
            k = $urandom_range(1, 4);
            g = $urandom_range(0, 1);
            p = $urandom_range(0, 1);
            pins[1] = p[0];
            wr(`ADDR_RUN_FLAGS, 8'h00);
            wr(`ADDR_TIMER0_LOW, lo);
            wr(`ADDR_TIMER0_HIGH, hi);
            wr(`ADDR_MODE_CONTROL, {4'h0, g[0], 1'b1, m[1:0]});
            wr(`ADDR_RUN_FLAGS, 8'h10);
            fall(5, k);
            c = (g == 0 || p == 1) ? k : 0;
            ov = 0;
            case (m)
                0: begin
                    c = c + {hi, lo[4:0]};
                    ov = c > 16'h1FFF;
                    lo = {lo[7:5], c[4:0]};
                    hi = c[12:5];
                end
                1: begin
                    c = c + {hi, lo};
                    ov = c > 16'hFFFF;
                    {hi, lo} = c[15:0];
                end
                2: repeat (c) begin
                    ov = ov | (lo == 8'hFF);
                    lo = (lo == 8'hFF) ? hi : lo + 8'h01;
                end
                default: begin
                    c = c + lo;
                    ov = c > 8'hFF;
                    lo = c[7:0];
                end
            endcase
            rd(`ADDR_TIMER0_LOW, d);
            chk("timer0 low", lo, d);
            rd(`ADDR_TIMER0_HIGH, d);
            chk("timer0 high", hi, d);
            rd(`ADDR_RUN_FLAGS, d);
            chk("timer0 flags", {2'h0, ov[0], 1'b1, 4'h0}, {d[7:4], 4'h0});
        end
        pins[1] = 1'b1;
        $display("test timer0 modes done");
        for (int e = 0; e < 2; e++) begin
            lo = $urandom;
            hi = $urandom;
            ld2({hi, lo, 16'h0000});
            wr(`ADDR_TIMER2_CONTROL, {4'h0, e[0], 3'h1});
            fall(2, 1);
            rd(`ADDR_TIMER2_CAP_LOW, d);
            chk("capture low", e ? lo : 8'h00, d);
            rd(`ADDR_TIMER2_CAP_HIGH, d);
            chk("capture high", e ? hi : 8'h00, d);
            rd(`ADDR_TIMER2_CONTROL, d);
            chk("external flag", {1'b0, e[0], 2'h0, e[0], 3'h1}, d);
        end
        ld2({16'hFFFF, hi, lo});
        pulses = 0;
        wr(`ADDR_TIMER2_CONTROL, 8'h06);
        fall(3, 1);
        rd(`ADDR_TIMER2_LOW, d);
        chk("reload low", lo, d);
        rd(`ADDR_TIMER2_CONTROL, d);
        chk("overflow flag", 8'h86, d);
        chk("overflow pulses", 16'h0001, pulses[15:0]);
        ld2(32'hFFF0_FFF0);
        wr(`ADDR_TIMER2_CONTROL, 8'h34);
        bauds = 0;
        repeat (320) @(negedge core_clk);
        // 16 steps of 2 clocks per shift clock
        chk("baud ticks", 1'b1, bauds >= 9 && bauds <= 11);
        rd(`ADDR_TIMER2_CONTROL, d);
        chk("baud flag", 8'h34, d);
        wr(`ADDR_TIMER2_CONTROL, 8'h00);
        $display("test timer2 done");
        ack_enable = 1'b1;
        wr(`ADDR_RUN_FLAGS, 8'hA1);
        fall(1, 1);
        rd(`ADDR_RUN_FLAGS, d);
        chk("acked flags", 8'h01, d);
        $display("test interrupts done");
        end_sim();
    end
endmodule : triple_timer_counter_test
bind triple_timer_counter triple_timer_counter_asserts triple_timer_counter_asserts_inst (.core_clk(core_clk),
    .resetn(resetn), .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .vector_ack(vector_ack), .irq_req(irq_req), .baud_clock(baud_clock),
    .timer2_overflow_pulse(timer2_overflow_pulse));
